// ==== common/ftc_pkg.sv ====
/*
 * Constants, types and register map of the fault-tolerant CAN transceiver
 * control logic.
 * Assumes a 100 MHz hclk and an AHB-Lite master for the register bus.
 */
package ftc_pkg;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam int CLK_PERIOD_NS = 10;
  localparam int DOM_TIMEOUT_NS = 1000000;
  localparam int DOM_TIMEOUT_CYC = DOM_TIMEOUT_NS / CLK_PERIOD_NS;

  // ************************************************************
  // Register map (byte addresses)
  // ************************************************************
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;

  // CTRL fields
  localparam int CTRL_TX_EN_BIT = 0;
  localparam logic CTRL_TX_EN_RST = 1'b1;

  // STATUS fields
  localparam int ST_STATE_LSB = 0;
  localparam int ST_LINE_LSB = 2;
  localparam int ST_DOM_TO_BIT = 4;
  localparam int ST_FLAG_N_BIT = 5;
  localparam int ST_PWRON_BIT = 6;
  localparam int ST_WAKE_BIT = 7;

  // Interrupt status / mask fields
  localparam int IRQ_W = 3;
  localparam int IRQ_DOM_TO_BIT = 0;
  localparam int IRQ_FAULT_BIT = 1;
  localparam int IRQ_WAKE_BIT = 2;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;

  // ************************************************************
  // Types
  // ************************************************************
  // Gray along normal -> power-on standby -> standby -> sleep
  typedef enum logic [1:0] {
    ST_NORMAL = 2'b00,
    ST_PWRON_STBY = 2'b01,
    ST_STANDBY = 2'b11,
    ST_SLEEP = 2'b10
  } ftc_state_t;

  typedef enum logic [1:0] {
    LINE_DIFF = 2'b00,
    LINE_CANH_ONLY = 2'b01,
    LINE_CANL_ONLY = 2'b10
  } ftc_line_t;

  // Pin-side inputs, all asynchronous to hclk
  typedef struct packed {
    logic tx_data_n;
    logic standby_ctl;
    logic mode_ctl;
    logic local_wake_n;
    logic diff_rx_n;
    logic canh_rx_n;
    logic canl_rx_n;
    logic canh_fail;
    logic canl_fail;
  } ftc_pins_t;

  localparam int PINS_W = $bits(ftc_pins_t);
  // Idle levels seen before the first synchronised sample
  // Control pair idles at power-on standby so the flag set by reset survives
  localparam logic [PINS_W-1:0] PINS_IDLE = 9'h1BC;

  // Bus-side outputs
  typedef struct packed {
    logic canh_drive;
    logic canl_drive;
    logic high_line_termination_weak;
    logic low_line_termination_weak;
  } ftc_bus_t;

endpackage : ftc_pkg

// ==== verilog/ftc_sync.sv ====
/*
 * Two-flop synchroniser for a group of asynchronous levels.
 * Assumes the inputs are slow levels; multi-bit groups are not coherent.
 */
`timescale 1ns/1ps
module ftc_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] meta_r;

  // ************************************************************
  // Stages
  // ************************************************************
  // First stage is read only by the second
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_r <= RST_VAL;
      q <= RST_VAL;
    end
    else
    begin
      meta_r <= d;
      q <= meta_r;
    end
  end

endmodule : ftc_sync

// ==== verilog/ftc_ctrl.sv ====
/*
 * Digital control of a fault-tolerant low-speed CAN transceiver: transmit
 * gating with dominant time-out, failure-driven line selection, operating
 * state decode, indication and inhibit outputs, AHB-Lite register slave.
 * Assumes analogue comparators deliver receiver and failure levels on pins.
 */
`timescale 1ns/1ps
module ftc_ctrl #(
  parameter int DOM_CYC = ftc_pkg::DOM_TIMEOUT_CYC
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Pins from controller and analogue front end
  input wire ftc_pkg::ftc_pins_t pins,
  // Bus drivers and terminations
  output ftc_pkg::ftc_bus_t bus,
  // Controller-facing outputs
  output logic rx_data,
  output logic fault_wake_flag_n,
  // Regulator inhibit, three-state
  output logic regulator_inhibit_out,
  output logic regulator_inhibit_oe,
  // Interrupt
  output logic irq
);
  import ftc_pkg::*;

  // ************************************************************
  // Input synchronisation
  // ************************************************************
  logic [PINS_W-1:0] pins_q;
  ftc_pins_t ps;

  ftc_sync #(
    .W(PINS_W),
    .RST_VAL(PINS_IDLE)
  ) u_sync (
    .clk(hclk),
    .rst_n(hresetn),
    .d(pins),
    .q(pins_q)
  );

  assign ps = ftc_pins_t'(pins_q);

  // ************************************************************
  // State registers
  // ************************************************************
  ftc_state_t state_r, state_nxt;
  ftc_line_t line_r, line_nxt;
  logic [31:0] dom_cnt_r, dom_cnt_nxt;
  logic dom_to_r, dom_to_nxt;
  logic wake_prev_r, wake_prev_nxt;
  logic wake_r, wake_nxt;
  logic pwron_r, pwron_nxt;
  logic goto_sleep_r, goto_sleep_nxt;
  logic wake_edge;
  logic ctl_lowpwr;

  // Width cast once so the compare below has no implicit resize
  localparam logic [31:0] DOM_LAST = 32'(DOM_CYC - 1);

  assign wake_edge = ps.local_wake_n ^ wake_prev_r;
  assign ctl_lowpwr = !ps.standby_ctl && !ps.mode_ctl;

  // ************************************************************
  // Operating state and line selection
  // ************************************************************
  always_comb
  begin
    state_nxt = state_r;
    goto_sleep_nxt = goto_sleep_r;
    // Decode the pair of control inputs together
    case ({ps.standby_ctl, ps.mode_ctl})
      2'b11:
      begin
        state_nxt = ST_NORMAL;
        goto_sleep_nxt = 1'b0;
      end
      2'b10:
      begin
        state_nxt = ST_PWRON_STBY;
        goto_sleep_nxt = 1'b0;
      end
      2'b01:
      begin
        // Goto-sleep: regulator still on until the pins go low-low
        state_nxt = ST_STANDBY;
        goto_sleep_nxt = 1'b1;
      end
      default:
      begin
        if (goto_sleep_r && state_r != ST_SLEEP)
        begin
          state_nxt = ST_SLEEP;
        end
        else if (state_r == ST_NORMAL || state_r == ST_PWRON_STBY)
        begin
          state_nxt = ST_STANDBY;
        end
        goto_sleep_nxt = 1'b0;
      end
    endcase
    // A wake-up in sleep brings the regulator back on
    if (state_r == ST_SLEEP && ctl_lowpwr && (wake_r || wake_edge))
    begin
      state_nxt = ST_STANDBY;
    end
  end

  always_comb
  begin
    line_nxt = line_r;
    // Failure logic runs only in normal mode; no software command needed
    if (state_r == ST_NORMAL)
    begin
      if (ps.canl_fail)
      begin
        line_nxt = LINE_CANH_ONLY;
      end
      else if (ps.canh_fail)
      begin
        line_nxt = LINE_CANL_ONLY;
      end
      else
      begin
        line_nxt = LINE_DIFF;
      end
    end
  end

  // ************************************************************
  // Dominant time-out
  // ************************************************************
  always_comb
  begin
    dom_cnt_nxt = dom_cnt_r;
    dom_to_nxt = dom_to_r;
    if (ps.tx_data_n)
    begin
      // Any high level restarts the timer and re-enables transmit
      dom_cnt_nxt = 32'h0000_0000;
      dom_to_nxt = 1'b0;
    end
    else if (!dom_to_r)
    begin
      if (dom_cnt_r >= DOM_LAST)
      begin
        dom_to_nxt = 1'b1;
      end
      else
      begin
        dom_cnt_nxt = dom_cnt_r + 32'h0000_0001;
      end
    end
  end

  // ************************************************************
  // Wake and power-on flags
  // ************************************************************
  always_comb
  begin
    wake_prev_nxt = ps.local_wake_n;
    wake_nxt = wake_r;
    pwron_nxt = pwron_r;
    if (state_r == ST_NORMAL)
    begin
      wake_nxt = 1'b0;
      pwron_nxt = 1'b0;
    end
    // Set only outside normal mode, so an edge in a clearing cycle is dropped
    if (wake_edge && state_r != ST_NORMAL)
    begin
      wake_nxt = 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_r <= ST_PWRON_STBY;
      line_r <= LINE_DIFF;
      dom_cnt_r <= 32'h0000_0000;
      dom_to_r <= 1'b0;
      wake_prev_r <= 1'b1;
      wake_r <= 1'b0;
      pwron_r <= 1'b1;
      goto_sleep_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      line_r <= line_nxt;
      dom_cnt_r <= dom_cnt_nxt;
      dom_to_r <= dom_to_nxt;
      wake_prev_r <= wake_prev_nxt;
      wake_r <= wake_nxt;
      pwron_r <= pwron_nxt;
      goto_sleep_r <= goto_sleep_nxt;
    end
  end

  // ************************************************************
  // Register file and AHB-Lite slave
  // ************************************************************
  logic ctrl_tx_en_r, ctrl_tx_en_nxt;
  logic [IRQ_W-1:0] irq_stat_r, irq_stat_nxt;
  logic [IRQ_W-1:0] irq_mask_r, irq_mask_nxt;
  logic wr_pend_r, wr_pend_nxt;
  logic [7:0] addr_r, addr_nxt;
  logic [31:0] hrdata_r, hrdata_nxt;
  logic [IRQ_W-1:0] evt;
  logic [31:0] status_word;
  logic acc;

  assign acc = hsel && htrans[1] && hready;

  assign evt[IRQ_DOM_TO_BIT] = dom_to_nxt && !dom_to_r;
  assign evt[IRQ_FAULT_BIT] = (line_nxt != LINE_DIFF) && (line_r == LINE_DIFF);
  assign evt[IRQ_WAKE_BIT] = wake_nxt && !wake_r;

  always_comb
  begin
    status_word = 32'h0000_0000;
    status_word[ST_STATE_LSB +: 2] = state_r;
    status_word[ST_LINE_LSB +: 2] = line_r;
    status_word[ST_DOM_TO_BIT] = dom_to_r;
    status_word[ST_FLAG_N_BIT] = fault_wake_flag_n;
    status_word[ST_PWRON_BIT] = pwron_r;
    status_word[ST_WAKE_BIT] = wake_r;
  end

  always_comb
  begin
    wr_pend_nxt = acc && hwrite;
    addr_nxt = acc ? haddr[7:0] : addr_r;
    ctrl_tx_en_nxt = ctrl_tx_en_r;
    irq_mask_nxt = irq_mask_r;
    irq_stat_nxt = irq_stat_r;
    hrdata_nxt = hrdata_r;
    if (wr_pend_r)
    begin
      case (addr_r)
        ADDR_CTRL: ctrl_tx_en_nxt = hwdata[CTRL_TX_EN_BIT];
        ADDR_IRQ_STAT: irq_stat_nxt = irq_stat_r & ~hwdata[IRQ_W-1:0];
        ADDR_IRQ_MASK: irq_mask_nxt = hwdata[IRQ_W-1:0];
        default: ;
      endcase
    end
    // Events override a write-one-to-clear in the same cycle
    irq_stat_nxt = irq_stat_nxt | evt;
    if (acc && !hwrite)
    begin
      case (haddr[7:0])
        ADDR_CTRL: hrdata_nxt = {31'h0000_0000, ctrl_tx_en_r};
        ADDR_STATUS: hrdata_nxt = status_word;
        ADDR_IRQ_STAT: hrdata_nxt = {29'h0000_0000, irq_stat_r};
        ADDR_IRQ_MASK: hrdata_nxt = {29'h0000_0000, irq_mask_r};
        default: hrdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_r <= 1'b0;
      addr_r <= 8'h00;
      ctrl_tx_en_r <= CTRL_TX_EN_RST;
      irq_stat_r <= '0;
      irq_mask_r <= IRQ_MASK_RST;
      hrdata_r <= 32'h0000_0000;
    end
    else
    begin
      wr_pend_r <= wr_pend_nxt;
      addr_r <= addr_nxt;
      ctrl_tx_en_r <= ctrl_tx_en_nxt;
      irq_stat_r <= irq_stat_nxt;
      irq_mask_r <= irq_mask_nxt;
      hrdata_r <= hrdata_nxt;
    end
  end

  assign hrdata = hrdata_r;
  // Zero-wait slave, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // ************************************************************
  // Output stage
  // ************************************************************
  ftc_bus_t bus_r, bus_nxt;
  logic rx_r, rx_nxt;
  logic flag_n_r, flag_n_nxt;
  logic inh_r, inh_nxt;
  logic inh_oe_r, inh_oe_nxt;
  logic irq_r, irq_nxt;
  logic tx_dom;

  // Transmit only in normal mode, before time-out, when software allows
  assign tx_dom = !ps.tx_data_n && !dom_to_nxt && ctrl_tx_en_r
                  && state_nxt == ST_NORMAL;

  always_comb
  begin
    bus_nxt.canh_drive = tx_dom && line_nxt != LINE_CANL_ONLY;
    bus_nxt.canl_drive = tx_dom && line_nxt != LINE_CANH_ONLY;
    bus_nxt.high_line_termination_weak = line_nxt == LINE_CANL_ONLY;
    bus_nxt.low_line_termination_weak = line_nxt == LINE_CANH_ONLY;
    case (state_nxt)
      ST_NORMAL:
      begin
        case (line_nxt)
          LINE_CANH_ONLY: rx_nxt = ps.canh_rx_n;
          LINE_CANL_ONLY: rx_nxt = ps.canl_rx_n;
          default: rx_nxt = ps.diff_rx_n;
        endcase
        flag_n_nxt = line_nxt == LINE_DIFF;
      end
      ST_PWRON_STBY:
      begin
        rx_nxt = !wake_nxt;
        flag_n_nxt = !pwron_nxt;
      end
      default:
      begin
        rx_nxt = !wake_nxt;
        flag_n_nxt = !wake_nxt;
      end
    endcase
    // Sleep releases the pin; external pull-down turns the regulator off
    inh_oe_nxt = state_nxt != ST_SLEEP;
    inh_nxt = state_nxt != ST_SLEEP;
    irq_nxt = |(irq_stat_nxt & irq_mask_nxt);
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      bus_r <= '0;
      rx_r <= 1'b1;
      flag_n_r <= 1'b1;
      inh_r <= 1'b1;
      inh_oe_r <= 1'b1;
      irq_r <= 1'b0;
    end
    else
    begin
      bus_r <= bus_nxt;
      rx_r <= rx_nxt;
      flag_n_r <= flag_n_nxt;
      inh_r <= inh_nxt;
      inh_oe_r <= inh_oe_nxt;
      irq_r <= irq_nxt;
    end
  end

  assign bus = bus_r;
  assign rx_data = rx_r;
  assign fault_wake_flag_n = flag_n_r;
  assign regulator_inhibit_out = inh_r;
  assign regulator_inhibit_oe = inh_oe_r;
  assign irq = irq_r;

endmodule : ftc_ctrl

// ==== verification/ftc_ctrl_props.sv ====
/*
 * Port-level checker for the transceiver control block.
 * Assumes pin levels settle into outputs within three to five hclk edges.
 */
`timescale 1ns/1ps
module ftc_ctrl_chk #(
  parameter int DOM_CYC = ftc_pkg::DOM_TIMEOUT_CYC
) (
  // Clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // Observed ports
  input wire ftc_pkg::ftc_pins_t pins,
  input wire ftc_pkg::ftc_bus_t bus,
  input wire logic rx_data,
  input wire logic fault_wake_flag_n,
  input wire logic regulator_inhibit_out,
  input wire logic regulator_inhibit_oe,
  input wire logic hreadyout,
  input wire logic hresp
);
  import ftc_pkg::*;
  // ************************************************************
  // Helpers and properties
  // ************************************************************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic nrm, nof, sb, lp;
  int lo_cnt_r, lo_cnt_nxt;
  assign nrm = pins.standby_ctl && pins.mode_ctl;
  assign nof = !pins.canh_fail && !pins.canl_fail;
  assign sb = !pins.standby_ctl && pins.mode_ctl;
  assign lp = !pins.standby_ctl;
  // Leads the design's synced count by the sync delay, hence the margins
  always_comb lo_cnt_nxt = pins.tx_data_n ? 0 : (lo_cnt_r < 1000 ? lo_cnt_r + 1 : lo_cnt_r);
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn) lo_cnt_r <= 0;
    else lo_cnt_r <= lo_cnt_nxt;
  property p_okay; hreadyout && !hresp; endproperty
  a_okay: assert property (p_okay) else $error("bus answer not ready or not okay");
  property p_tx_idle; pins.tx_data_n[*4] |-> !bus.canh_drive && !bus.canl_drive; endproperty
  a_tx_idle: assert property (p_tx_idle) else $error("drive without request");
  property p_tx_drive;
    (nrm && nof && !pins.tx_data_n && lo_cnt_r + 4 < DOM_CYC)[*6]
      |-> bus.canh_drive && bus.canl_drive;
  endproperty
  a_tx_drive: assert property (p_tx_drive) else $error("dominant request not driven");
  property p_dom_to; lo_cnt_r > DOM_CYC + 6 |-> !bus.canh_drive && !bus.canl_drive; endproperty
  a_dom_to: assert property (p_dom_to) else $error("drive kept after time-out");
  property p_canh_only; (nrm && pins.canl_fail)[*6] |-> !bus.canl_drive; endproperty
  a_canh_only: assert property (p_canh_only) else $error("low wire driven while faulty");
  property p_canl_only;
    (nrm && pins.canh_fail && !pins.canl_fail)[*6] |-> !bus.canh_drive;
  endproperty
  a_canl_only: assert property (p_canl_only) else $error("high wire driven while faulty");
  property p_diff; (nrm && nof)[*6] |-> bus.canh_drive == bus.canl_drive; endproperty
  a_diff: assert property (p_diff) else $error("wires unpaired without fault");
  property p_flag;
    (nrm && $stable(pins.canh_fail) && $stable(pins.canl_fail))[*6] |-> fault_wake_flag_n == nof;
  endproperty
  a_flag: assert property (p_flag) else $error("fault flag wrong in normal");
  property p_rx;
    (nrm && nof && $stable(pins.diff_rx_n))[*6] |-> rx_data == pins.diff_rx_n;
  endproperty
  a_rx: assert property (p_rx) else $error("receive output differs");
  property p_sleep; !regulator_inhibit_oe |-> !$past(pins.standby_ctl, 4); endproperty
  a_sleep: assert property (p_sleep) else $error("inhibit released outside sleep");
  property p_stby; sb[*4] |-> regulator_inhibit_oe && regulator_inhibit_out; endproperty
  a_stby: assert property (p_stby) else $error("inhibit not driven in standby");
  property p_wake;
    lp[*4] ##1 (lp && $changed(pins.local_wake_n)) ##1 lp[*5] |-> !fault_wake_flag_n && !rx_data;
  endproperty
  a_wake: assert property (p_wake) else $error("wake edge not indicated");
endmodule : ftc_ctrl_chk

bind ftc_ctrl ftc_ctrl_chk #(.DOM_CYC(DOM_CYC)) u_chk (.hclk, .hresetn, .pins, .bus, .rx_data,
  .fault_wake_flag_n, .regulator_inhibit_out, .regulator_inhibit_oe, .hreadyout, .hresp);

// ==== verification/ftc_bus_model.sv ====
/*
 * Protocol controller and bus wires facing the transceiver control.
 * Assumes wired-or dominance and that a shorted wire reads dominant.
 */
`timescale 1ns/1ps
module ftc_bus_model (
  // Controller levels
  input wire logic tx_n,
  input wire logic sby,
  input wire logic mode,
  input wire logic wake_n,
  // Wire faults
  input wire logic fail_h,
  input wire logic fail_l,
  // Transceiver side
  input wire ftc_pkg::ftc_bus_t bus,
  output ftc_pkg::ftc_pins_t pins
);
  import ftc_pkg::*;
  logic dom;
  assign dom = bus.canh_drive || bus.canl_drive;
  always_comb
  begin
    pins.tx_data_n = tx_n;
    pins.standby_ctl = sby;
    pins.mode_ctl = mode;
    pins.local_wake_n = wake_n;
    pins.diff_rx_n = !dom;
    pins.canh_rx_n = fail_h ? 1'b0 : !dom;
    pins.canl_rx_n = fail_l ? 1'b0 : !dom;
    pins.canh_fail = fail_h;
    pins.canl_fail = fail_l;
  end
endmodule : ftc_bus_model

// ==== verification/fault_tolerant_can_phy_control_test.sv ====
/*
 * Self-checking bench: AHB-Lite register access plus pin-level scenarios.
 * Assumes zero-wait slave and outputs settled a few edges after pin changes.
 */
`timescale 1ns/1ps
module fault_tolerant_can_phy_control_test;
  import ftc_pkg::*;
  localparam int DOM = 20;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic hreadyout, hresp, rx_data, fault_wake_flag_n, irq;
  logic regulator_inhibit_out, regulator_inhibit_oe;
  logic tx_n = 1'b1, sby = 1'b1, mode = 1'b0, wake_n = 1'b1, fail_h = 1'b0, fail_l = 1'b0;
  ftc_pins_t pins;
  ftc_bus_t bus;
  int failures = 0, n_tests = 0, cyc = 0;

  always #5 hclk = ~hclk;

  ftc_ctrl #(.DOM_CYC(DOM)) dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .pins, .bus, .rx_data,
    .fault_wake_flag_n, .regulator_inhibit_out, .regulator_inhibit_oe, .irq);
  ftc_bus_model u_bus (.tx_n, .sby, .mode, .wake_n, .fail_h, .fail_l, .bus, .pins);

  // ************************************************************
  // Tasks
  // ************************************************************
  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : results

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      failures++;
      $display("[FAIL] %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wt(input int n);
    repeat (n) @(posedge hclk);
  endtask : wt

  // One single transfer; read data taken at the edge ending the data phase
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : xfer

  always @(posedge hclk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      failures++;
      results();
    end
  end

  // ************************************************************
  // Scenarios
  // ************************************************************
  initial
  begin
    wt(10);
    hresetn <= 1'b1;
    wt(8);
    chk(fault_wake_flag_n, 1'b0);
    chk(rx_data, 1'b1);
    chk({regulator_inhibit_oe, regulator_inhibit_out}, 2'h3);
    xfer(ADDR_STATUS, 1'b0, 32'h0);
    chk(rd, 32'h41);
    xfer(8'h10, 1'b0, 32'h0);
    chk(rd, 32'h0);
    xfer(ADDR_IRQ_MASK, 1'b0, 32'h0);
    chk(rd, 32'h0);
    wake_n <= 1'b0;
    wt(6);
    chk(rx_data, 1'b0);
    mode <= 1'b1;
    wt(6);
    xfer(ADDR_STATUS, 1'b0, 32'h0);
    chk(rd, 32'h20);
    // Receive loops back through the wires and the sync again: six edges
    tx_n <= 1'b0;
    wt(8);
    chk({bus.canh_drive, bus.canl_drive}, 2'h3);
    chk(rx_data, 1'b0);
    tx_n <= 1'b1;
    wt(8);
    chk({bus.canh_drive, bus.canl_drive}, 2'h0);
    chk(rx_data, 1'b1);
    // Software transmit gate blocks the driver
    xfer(ADDR_CTRL, 1'b0, 32'h0);
    chk(rd, 32'h1);
    xfer(ADDR_CTRL, 1'b1, 32'h0);
    tx_n <= 1'b0;
    wt(4);
    chk({bus.canh_drive, bus.canl_drive}, 2'h0);
    tx_n <= 1'b1;
    xfer(ADDR_CTRL, 1'b1, 32'h1);
    // Stuck dominant request, then recovery after a high level
    tx_n <= 1'b0;
    wt(DOM + 10);
    chk({bus.canh_drive, bus.canl_drive}, 2'h0);
    xfer(ADDR_STATUS, 1'b0, 32'h0);
    chk(rd[ST_DOM_TO_BIT], 1'b1);
    tx_n <= 1'b1;
    wt(6);
    tx_n <= 1'b0;
    wt(6);
    chk({bus.canh_drive, bus.canl_drive}, 2'h3);
    tx_n <= 1'b1;
    wt(6);
    // Interrupt: masked, unmasked, cleared by writing one
    xfer(ADDR_IRQ_STAT, 1'b0, 32'h0);
    chk(rd, 32'h5);
    chk(irq, 1'b0);
    xfer(ADDR_IRQ_MASK, 1'b1, 32'h1);
    wt(3);
    chk(irq, 1'b1);
    xfer(ADDR_IRQ_STAT, 1'b1, 32'h1);
    wt(3);
    chk(irq, 1'b0);
    xfer(ADDR_IRQ_STAT, 1'b0, 32'h0);
    chk(rd, 32'h4);
    xfer(ADDR_IRQ_STAT, 1'b1, 32'h4);
    // Wire faults: low wire wins when both fail
    for (int i = 1; i < 4; i++)
    begin
      {fail_h, fail_l} <= i[1:0];
      tx_n <= 1'b0;
      wt(8);
      chk({bus.canh_drive, bus.canl_drive}, i[0] ? 2'h2 : 2'h1);
      chk({bus.high_line_termination_weak, bus.low_line_termination_weak},
          i[0] ? 2'h1 : 2'h2);
      chk(fault_wake_flag_n, 1'b0);
      {fail_h, fail_l} <= 2'h0;
      tx_n <= 1'b1;
      wt(8);
      chk(fault_wake_flag_n, 1'b1);
    end
    xfer(ADDR_IRQ_STAT, 1'b0, 32'h0);
    chk(rd, 32'h2);
    chk(irq, 1'b0);
    xfer(ADDR_IRQ_MASK, 1'b1, 32'h2);
    wt(3);
    chk(irq, 1'b1);
    xfer(ADDR_IRQ_STAT, 1'b1, 32'h2);
    wt(3);
    chk(irq, 1'b0);
    // Low-power states and wake on a rising local edge
    sby <= 1'b0;
    wt(6);
    chk({regulator_inhibit_oe, regulator_inhibit_out}, 2'h3);
    chk({fault_wake_flag_n, rx_data}, 2'h3);
    mode <= 1'b0;
    wt(6);
    chk(regulator_inhibit_oe, 1'b0);
    tx_n <= 1'b0;
    wt(6);
    chk({bus.canh_drive, bus.canl_drive}, 2'h0);
    wake_n <= 1'b1;
    wt(8);
    chk({regulator_inhibit_oe, regulator_inhibit_out}, 2'h3);
    chk({fault_wake_flag_n, rx_data}, 2'h0);
    xfer(ADDR_STATUS, 1'b0, 32'h0);
    chk(rd[1:0], 2'h3);
    tx_n <= 1'b1;
    sby <= 1'b1;
    mode <= 1'b1;
    wt(8);
    chk(fault_wake_flag_n, 1'b1);
    results();
  end
endmodule : fault_tolerant_can_phy_control_test
